// ---- buf_mem_model.sv ----
// buffer memory model acking dma transfers, prompt or slow
`timescale 1ns/1ns
`default_nettype none
module buf_mem_model (
  input wire logic mclk, srst, en, slow, tx_active, xfer_busy,
  output var logic tx_byte_done, xfer_step
);
  logic ph_q;
  always @(posedge mclk) begin
    ph_q <= !srst && !ph_q;
    tx_byte_done <= !srst && en && tx_active && (!slow || ph_q);
    xfer_step <= !srst && en && xfer_busy && (!slow || ph_q);
  end
endmodule
`default_nettype wire

// ---- mac_dma_filter_tally_regs.v ----
// register bank: dma pointers, address filter and error tallies
`timescale 1ns/1ns
`default_nettype none
`include "mac_regs_defines.vh"
// Behaviour
// - transmit length is sent in full, never truncated beyond 1500 bytes
// - ring first and last page registers hold address bits 15 to 8 only
// - next page equal to guard page aborts the local dma
// - write page holds packet first page; error restores local pointer from it
// - local dma address readable as high byte 15..8 and low byte 7..0
// - host transfer start address: low register bits 0..7, high bits 8..15
// - host transfer count is 16 bits, low and high byte registers
// - host transfer address steps two per word, one per byte
// - host transfer count drops two per word, one per byte
// - current host transfer address readable as two bytes, high holds 15..8
// - destination compared byte by byte against six station address bytes
// - first destination bit is the group address flag
// - all destinations pass the crc; top 6 bits latched after last bit
// - 6 hash bits select one of 64 filter bits; multicast needs it set
// - filter bit n lives in byte n/8 at bit n mod 8
// - tallies are 8-bit binary counters that stop at 192
// - reading a tally returns its value and clears it
// - alignment tally counts address-matched packets with alignment error
// - crc tally counts address-matched packets with crc error
// - transmit dma start: high byte from tx page pointer, low byte zero
// - an alignment error also raises the crc error indication
module mac_dma_filter_tally_regs (
  // clock and reset
  input wire mclk,
  input wire srst,
  // register port
  input wire [4:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // transmit local dma
  input wire tx_start,
  input wire tx_byte_done,
  output reg tx_active,
  output wire [15:0] tx_length,
  // receive local dma
  input wire rx_start,
  input wire rx_byte_done,
  input wire rx_error,
  output reg rx_abort,
  output reg [15:0] local_addr,
  // host transfer dma
  input wire xfer_start,
  input wire xfer_step,
  input wire xfer_word,
  output reg xfer_busy,
  output reg [15:0] xfer_addr,
  // serial destination address in
  input wire da_start,
  input wire da_bit_valid,
  input wire da_bit,
  output reg da_done,
  output reg da_accept,
  output reg da_group,
  // packet end status
  input wire pkt_end,
  input wire pkt_crc_bad,
  input wire pkt_misaligned,
  output reg pkt_crc_error
);
  reg [7:0] tx_len_lo_q;
  reg [7:0] tx_len_hi_q;
  reg [7:0] first_pg_q;
  reg [7:0] last_pg_q;
  reg [7:0] guard_pg_q;
  reg [7:0] write_pg_q;
  reg [7:0] tx_pg_q;
  reg [7:0] start_lo_q;
  reg [7:0] start_hi_q;
  reg [7:0] cnt_lo_q;
  reg [7:0] cnt_hi_q;
  reg [7:0] align_tally_q;
  reg [7:0] crc_tally_q;
  reg [7:0] station_q [0:5];
  reg [7:0] hash_q [0:7];
  reg [15:0] tx_left_q;
  reg [15:0] xfer_cnt_q;
  reg [47:0] da_sr_q;
  reg [31:0] crc_q;
  reg [5:0] bit_cnt_q;
  reg [5:0] hash_idx_q;
  reg da_match_q;
  reg [7:0] rdata_d;

  // saturating tally step
  function [7:0] tally_inc;
    input [7:0] v;
    begin
      tally_inc = (v >= `TALLY_MAX) ? v : v + 8'h01;
    end
  endfunction

  // one serial crc step, msb first
  function [31:0] crc_next;
    input [31:0] c;
    input b;
    begin
      crc_next = {c[30:0], 1'b0} ^ ((c[31] ^ b) ? `CRC_POLY : 32'h00000000);
    end
  endfunction

  // ring page after the given one, wrapping at the last page
  function [7:0] page_after;
    input [7:0] pg;
    input [7:0] first;
    input [7:0] last;
    reg [7:0] inc;
    begin
      inc = pg + 8'h01;
      page_after = (inc == last) ? first : inc;
    end
  endfunction

  // filter bit n sits in byte n/8 at bit n mod 8
  function filter_bit;
    input [63:0] filt;
    input [5:0] idx;
    begin
      filter_bit = filt[idx];
    end
  endfunction

  // host transfer stride: two per word, one per byte
  function [15:0] xfer_stride;
    input word;
    begin
      xfer_stride = word ? 16'h0002 : 16'h0001;
    end
  endfunction

  assign tx_length = {tx_len_hi_q, tx_len_lo_q};

  wire [7:0] next_pg = page_after(local_addr[15:8], first_pg_q, last_pg_q);
  wire [15:0] step = xfer_stride(xfer_word);
  wire rd_align = reg_rd && reg_addr == `OFS_ALIGN_ERROR_TALLY;
  wire rd_crc = reg_rd && reg_addr == `OFS_CRC_ERROR_TALLY;
  wire crc_err = pkt_crc_bad | pkt_misaligned;
  wire [31:0] crc_step = crc_next(crc_q, da_bit);
  wire [47:0] station_word = {station_q[5], station_q[4], station_q[3],
                              station_q[2], station_q[1], station_q[0]};
  wire [63:0] hash_flat = {hash_q[7], hash_q[6], hash_q[5], hash_q[4],
                           hash_q[3], hash_q[2], hash_q[1], hash_q[0]};
  wire hash_hit = filter_bit(hash_flat, hash_idx_q);
  wire station_hit = station_word == da_sr_q;
  wire addr_hit = da_sr_q[0] ? hash_hit : station_hit;
  wire page_end = local_addr[7:0] == 8'hFF;
  wire tx_last = tx_left_q == 16'h0001;
  wire [15:0] xfer_len = {cnt_hi_q, cnt_lo_q};
  wire xfer_last = xfer_cnt_q <= step;

  // register writes
  always @(posedge mclk) begin
    if (srst) begin
      tx_len_lo_q <= `RST_BYTE;
      tx_len_hi_q <= `RST_BYTE;
      first_pg_q <= `RST_BYTE;
      last_pg_q <= `RST_BYTE;
      guard_pg_q <= `RST_BYTE;
      write_pg_q <= `RST_BYTE;
      tx_pg_q <= `RST_BYTE;
      start_lo_q <= `RST_BYTE;
      start_hi_q <= `RST_BYTE;
      cnt_lo_q <= `RST_BYTE;
      cnt_hi_q <= `RST_BYTE;
      hash_q[0] <= `RST_BYTE;
      hash_q[1] <= `RST_BYTE;
      hash_q[2] <= `RST_BYTE;
      hash_q[3] <= `RST_BYTE;
      hash_q[4] <= `RST_BYTE;
      hash_q[5] <= `RST_BYTE;
      hash_q[6] <= `RST_BYTE;
      hash_q[7] <= `RST_BYTE;
      station_q[0] <= `RST_BYTE;
      station_q[1] <= `RST_BYTE;
      station_q[2] <= `RST_BYTE;
      station_q[3] <= `RST_BYTE;
      station_q[4] <= `RST_BYTE;
      station_q[5] <= `RST_BYTE;
    end else if (reg_wr) begin
      case (reg_addr)
        `OFS_TX_LENGTH_LOW: tx_len_lo_q <= reg_wdata;
        `OFS_TX_LENGTH_HIGH: tx_len_hi_q <= reg_wdata;
        `OFS_RX_RING_FIRST_PAGE: first_pg_q <= reg_wdata;
        `OFS_RX_RING_LAST_PAGE: last_pg_q <= reg_wdata;
        `OFS_RX_RING_GUARD_PAGE: guard_pg_q <= reg_wdata;
        `OFS_RX_WRITE_PAGE: write_pg_q <= reg_wdata;
        `OFS_TX_PAGE_POINTER: tx_pg_q <= reg_wdata;
        `OFS_HOST_XFER_START_LOW: start_lo_q <= reg_wdata;
        `OFS_HOST_XFER_START_HIGH: start_hi_q <= reg_wdata;
        `OFS_HOST_XFER_COUNT_LOW: cnt_lo_q <= reg_wdata;
        `OFS_HOST_XFER_COUNT_HIGH: cnt_hi_q <= reg_wdata;
        default: begin
          if (reg_addr[4:3] == 2'b11) begin
            hash_q[reg_addr[2:0]] <= reg_wdata;
          end else if (reg_addr[4:3] == 2'b10 && reg_addr[2:0] < 3'h6) begin
            station_q[reg_addr[2:0]] <= reg_wdata;
          end
        end
      endcase
    end
  end

  // transmit and receive local dma
  always @(posedge mclk) begin
    if (srst) begin
      tx_active <= 1'b0;
      tx_left_q <= 16'h0000;
      local_addr <= 16'h0000;
      rx_abort <= 1'b0;
    end else begin
      rx_abort <= 1'b0;
      if (tx_start) begin
        tx_active <= tx_length != 16'h0000;
        tx_left_q <= tx_length;
        local_addr <= {tx_pg_q, 8'h00};
      end else if (tx_active && tx_byte_done) begin
        local_addr <= local_addr + 16'h0001;
        tx_left_q <= tx_left_q - 16'h0001;
        if (tx_last) begin
          tx_active <= 1'b0;
        end
      end else if (rx_start) begin
        local_addr <= {write_pg_q, 8'h00};
      end else if (rx_error) begin
        local_addr <= {write_pg_q, 8'h00};
      end else if (rx_byte_done) begin
        if (page_end) begin
          if (next_pg == guard_pg_q) begin
            rx_abort <= 1'b1;
          end else begin
            local_addr <= {next_pg, 8'h00};
          end
        end else begin
          local_addr <= local_addr + 16'h0001;
        end
      end
    end
  end

  // host transfer dma
  always @(posedge mclk) begin
    if (srst) begin
      xfer_busy <= 1'b0;
      xfer_addr <= 16'h0000;
      xfer_cnt_q <= 16'h0000;
    end else if (xfer_start) begin
      xfer_addr <= {start_hi_q, start_lo_q};
      xfer_cnt_q <= xfer_len;
      xfer_busy <= xfer_len != 16'h0000;
    end else if (xfer_busy && xfer_step) begin
      xfer_addr <= xfer_addr + step;
      if (xfer_last) begin
        xfer_cnt_q <= 16'h0000;
        xfer_busy <= 1'b0;
      end else begin
        xfer_cnt_q <= xfer_cnt_q - step;
      end
    end
  end

  // destination address filter
  always @(posedge mclk) begin
    if (srst) begin
      crc_q <= `CRC_INIT;
      bit_cnt_q <= 6'h00;
      da_sr_q <= 48'h000000000000;
      hash_idx_q <= 6'h00;
      da_done <= 1'b0;
      da_accept <= 1'b0;
      da_group <= 1'b0;
      da_match_q <= 1'b0;
    end else begin
      da_done <= 1'b0;
      if (da_start) begin
        crc_q <= `CRC_INIT;
        bit_cnt_q <= 6'h00;
      end else if (da_bit_valid && bit_cnt_q < `DEST_BITS) begin
        crc_q <= crc_step;
        da_sr_q <= {da_bit, da_sr_q[47:1]};
        bit_cnt_q <= bit_cnt_q + 6'h01;
        if (bit_cnt_q == `DEST_BITS - 6'h01) begin
          hash_idx_q <= crc_step[31:26];
          da_done <= 1'b1;
        end
      end
      if (da_done) begin
        da_group <= da_sr_q[0];
        da_match_q <= addr_hit;
        da_accept <= addr_hit;
      end
    end
  end

  // alignment tally; an event on a read cycle counts from zero
  always @(posedge mclk) begin
    if (srst) begin
      align_tally_q <= `RST_BYTE;
    end else if (pkt_end && da_match_q && pkt_misaligned) begin
      align_tally_q <= rd_align ? 8'h01 : tally_inc(align_tally_q);
    end else if (rd_align) begin
      align_tally_q <= `RST_BYTE;
    end
  end

  // crc tally and packet crc flag
  always @(posedge mclk) begin
    if (srst) begin
      crc_tally_q <= `RST_BYTE;
      pkt_crc_error <= 1'b0;
    end else begin
      if (pkt_end) begin
        pkt_crc_error <= crc_err;
      end
      if (pkt_end && da_match_q && crc_err) begin
        crc_tally_q <= rd_crc ? 8'h01 : tally_inc(crc_tally_q);
      end else if (rd_crc) begin
        crc_tally_q <= `RST_BYTE;
      end
    end
  end

  // read data mux
  always @* begin
    rdata_d = `RST_BYTE;
    case (reg_addr)
      `OFS_TX_LENGTH_LOW: rdata_d = tx_len_lo_q;
      `OFS_TX_LENGTH_HIGH: rdata_d = tx_len_hi_q;
      `OFS_RX_RING_FIRST_PAGE: rdata_d = first_pg_q;
      `OFS_RX_RING_LAST_PAGE: rdata_d = last_pg_q;
      `OFS_RX_RING_GUARD_PAGE: rdata_d = guard_pg_q;
      `OFS_RX_WRITE_PAGE: rdata_d = write_pg_q;
      `OFS_LOCAL_ADDR_LOW: rdata_d = local_addr[7:0];
      `OFS_LOCAL_ADDR_HIGH: rdata_d = local_addr[15:8];
      `OFS_HOST_XFER_START_LOW: rdata_d = start_lo_q;
      `OFS_HOST_XFER_START_HIGH: rdata_d = start_hi_q;
      `OFS_HOST_XFER_COUNT_LOW: rdata_d = xfer_cnt_q[7:0];
      `OFS_HOST_XFER_COUNT_HIGH: rdata_d = xfer_cnt_q[15:8];
      `OFS_HOST_XFER_ADDR_LOW: rdata_d = xfer_addr[7:0];
      `OFS_HOST_XFER_ADDR_HIGH: rdata_d = xfer_addr[15:8];
      `OFS_ALIGN_ERROR_TALLY: rdata_d = align_tally_q;
      `OFS_CRC_ERROR_TALLY: rdata_d = crc_tally_q;
      `OFS_TX_PAGE_POINTER: rdata_d = tx_pg_q;
      `OFS_XFER_STATUS: rdata_d = {5'h00, da_match_q, tx_active, xfer_busy};
      default: begin
        if (reg_addr[4:3] == 2'b11) begin
          rdata_d = hash_q[reg_addr[2:0]];
        end else if (reg_addr[4:3] == 2'b10 && reg_addr[2:0] < 3'h6) begin
          rdata_d = station_q[reg_addr[2:0]];
        end
      end
    endcase
  end

  // read data one cycle after strobe
  always @(posedge mclk) begin
    if (srst) begin
      reg_rdata <= `RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end
  end
endmodule
`default_nettype wire

// ---- mac_dma_filter_tally_regs_tb_top.sv ----
// self-checking bench for the mac register bank
`timescale 1ns/1ns
`default_nettype none
module mac_dma_filter_tally_regs_tb_top;
  logic mclk, srst = 1, reg_wr = 0, reg_rd = 0, tx_start = 0, rx_start = 0, rx_error = 0;
  logic rx_byte_done = 0, xfer_start = 0, xfer_word = 0, da_start = 0, da_bit_valid = 0;
  logic da_bit = 0, pkt_end = 0, pkt_crc_bad = 0, pkt_misaligned = 0, en = 0, slow = 0;
  logic tx_byte_done, xfer_step, tx_active, rx_abort, xfer_busy, da_done, da_accept;
  logic da_group, pkt_crc_error;
  logic [4:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata;
  logic [7:0] e [32];
  logic [15:0] tx_length, local_addr, xfer_addr, len, sa, ea;
  logic [31:0] r = 32'hE95BB736;
  logic [47:0] st;
  int n_mismatch = 0, num_checks = 0, nstep, ntx, nab, i;
  mac_dma_filter_tally_regs mac_dma_filter_tally_regs_i (.*);
  buf_mem_model buf_mem_model_i (.*);
  function logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task give_verdict;
    if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] x, g);
    num_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk) reg_wr <= 0;
  endtask
  task rc(input logic [4:0] a, input logic [7:0] x);
    @(posedge mclk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge mclk) reg_rd <= 0;
    #1 chk($sformatf("reg %h", a), {8'h00, x}, {8'h00, reg_rdata});
  endtask
  task stall(input int lim);
    for (i = 0; i < lim && (tx_active | xfer_busy) === 1'b1; i++) #100;
    if (i == lim) begin
      n_mismatch++;
      give_verdict;
    end
  endtask
  task dchk(input logic [47:0] a, input logic x, g);
    @(posedge mclk) da_start <= 1;
    for (int k = 0; k < 48; k++) begin
      @(posedge mclk);
      da_start <= 0;
      da_bit_valid <= 1;
      da_bit <= a[k];
    end
    @(posedge mclk) da_bit_valid <= 0;
    repeat (2) @(posedge mclk);
    #1 chk("accept", {15'h0, x}, {15'h0, da_accept});
    chk("group", {15'h0, g}, {15'h0, da_group});
  endtask
  task pk(input logic b, m);
    @(posedge mclk);
    pkt_end <= 1;
    pkt_crc_bad <= b;
    pkt_misaligned <= m;
    @(posedge mclk) pkt_end <= 0;
    #1;
  endtask
  always @(posedge mclk) begin
    if (tx_active && tx_byte_done) ntx++;
    if (xfer_busy && xfer_step) nstep++;
    if (rx_abort) nab++;
  end
  initial begin
    mclk = 0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    repeat (5) @(posedge mclk);
    srst <= 0;
    for (int a = 0; a < 32; a++) rc(a[4:0], 8'h00);
    for (i = 0; i < 32; i++) begin
      r = nx(r);
      e[i] = r[7:0] & ((i == 16) ? 8'hFE : 8'hFF);
      if (!(i inside {10, 11, 14, 15, 23})) wr(i[4:0], e[i]);
      if (i inside {6, 7, 12, 13}) e[i] = 0;
    end
    for (int a = 0; a < 32; a++)
      if (!(a inside {10, 11, 14, 15, 23})) rc(a[4:0], e[a]);
    wr(5'h00, 8'h40);
    wr(5'h01, 8'h06);
    #1 chk("tx_length", 16'h0640, tx_length);
    @(posedge mclk) tx_start <= 1;
    @(posedge mclk) tx_start <= 0;
    rc(5'h07, e[22]);
    rc(5'h06, 8'h00);
    ntx = 0;
    en <= 1;
    slow <= 1;
    stall(4000);
    chk("tx bytes", 16'h0640, ntx[15:0]);
    wr(5'h02, 8'h40);
    wr(5'h03, 8'h42);
    wr(5'h04, 8'h41);
    wr(5'h05, 8'h40);
    nab = 0;
    @(posedge mclk) rx_start <= 1;
    @(posedge mclk) rx_start <= 0;
    #1 chk("local", 16'h4000, local_addr);
    @(posedge mclk) rx_byte_done <= 1;
    repeat (256) @(posedge mclk);
    rx_byte_done <= 0;
    #500 chk("abort", 16'h0001, nab[15:0]);
    chk("held", 16'h40FF, local_addr);
    @(posedge mclk) rx_error <= 1;
    @(posedge mclk) rx_error <= 0;
    #1 chk("local", 16'h4000, local_addr);
    for (int t = 0; t < 4; t++) begin
      r = nx(r);
      len = {10'h0, r[5:1], 1'b0} + 16'h0002;
      sa = r[31:16];
      ea = sa + len;
      wr(5'h08, sa[7:0]);
      wr(5'h09, sa[15:8]);
      wr(5'h0A, len[7:0]);
      wr(5'h0B, len[15:8]);
      slow <= r[6];
      xfer_word <= r[7];
      @(posedge mclk) xfer_start <= 1;
      @(posedge mclk) xfer_start <= 0;
      nstep = 0;
      #1 stall(300);
      chk("xfer addr", ea, xfer_addr);
      chk("steps", r[7] ? len >> 1 : len, nstep[15:0]);
      rc(5'h0A, 8'h00);
      rc(5'h0B, 8'h00);
      rc(5'h0C, ea[7:0]);
      rc(5'h0D, ea[15:8]);
    end
    st = {e[21], e[20], e[19], e[18], e[17], e[16]};
    for (i = 24; i < 32; i++) wr(i[4:0], 8'hFF);
    dchk({r[15:0], r[31:1], 1'b1}, 1, 1);
    for (i = 24; i < 32; i++) wr(i[4:0], 8'h00);
    dchk({r[15:0], r[31:1], 1'b1}, 0, 1);
    dchk(st, 1, 0);
    pk(0, 1);
    chk("crc flag", 16'h0001, {15'h0, pkt_crc_error});
    pk(1, 0);
    pk(0, 0);
    chk("crc clear", 16'h0000, {15'h0, pkt_crc_error});
    rc(5'h0E, 8'h01);
    rc(5'h0F, 8'h02);
    rc(5'h0E, 8'h00);
    repeat (200) pk(1, 1);
    rc(5'h0E, 8'hC0);
    rc(5'h0F, 8'hC0);
    rc(5'h0F, 8'h00);
    dchk(st ^ 48'h800000000000, 0, 0);
    pk(1, 1);
    rc(5'h0F, 8'h00);
    give_verdict;
  end
endmodule
`default_nettype wire

// ---- mac_regs_chk_assertions.sv ----
// assertion checker bound to the mac register bank
`timescale 1ns/1ns
`default_nettype none
module mac_regs_chk (
  input wire logic mclk, srst, reg_wr, reg_rd, tx_start, tx_byte_done, tx_active,
  input wire logic rx_start, rx_byte_done, rx_error, rx_abort, xfer_start, xfer_step,
  input wire logic xfer_word, xfer_busy, da_start, da_bit_valid, da_bit, da_done,
  input wire logic da_accept, da_group, pkt_end, pkt_crc_bad, pkt_misaligned,
  input wire logic pkt_crc_error,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata, reg_rdata,
  input wire logic [15:0] tx_length, local_addr, xfer_addr
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (srst);
  AST_TX_ADDR: assert property (tx_start |=> local_addr[7:0] == 8'h00)
    else $error("tx low addr");
  AST_RX_ADDR: assert property (rx_start && !tx_start && !tx_byte_done |=>
    local_addr[7:0] == 8'h00) else $error("rx low addr");
  AST_ABORT_PULSE: assert property (rx_abort |=> !rx_abort)
    else $error("abort too long");
  AST_XFER_BYTE: assert property (xfer_busy && xfer_step && !xfer_word && !xfer_start
    |=> xfer_addr == $past(xfer_addr) + 16'h0001) else $error("byte step");
  AST_XFER_WORD: assert property (xfer_busy && xfer_step && xfer_word && !xfer_start
    |=> xfer_addr == $past(xfer_addr) + 16'h0002) else $error("word step");
  AST_XFER_HOLD: assert property (!xfer_busy && !xfer_start |=> $stable(xfer_addr))
    else $error("idle addr moved");
  AST_DA_PULSE: assert property (da_done |=> !da_done)
    else $error("done too long");
  AST_CRC_FLAG: assert property (pkt_end |=>
    pkt_crc_error == $past(pkt_crc_bad || pkt_misaligned)) else $error("crc flag");
endmodule
bind mac_dma_filter_tally_regs mac_regs_chk mac_regs_chk_i (.*);
`default_nettype wire

// ---- mac_regs_defines.vh ----
// register offsets, reset values and limits for the mac register bank
`ifndef MAC_REGS_DEFINES_VH
`define MAC_REGS_DEFINES_VH
`define OFS_TX_LENGTH_LOW 5'h00
`define OFS_TX_LENGTH_HIGH 5'h01
`define OFS_RX_RING_FIRST_PAGE 5'h02
`define OFS_RX_RING_LAST_PAGE 5'h03
`define OFS_RX_RING_GUARD_PAGE 5'h04
`define OFS_RX_WRITE_PAGE 5'h05
`define OFS_LOCAL_ADDR_LOW 5'h06
`define OFS_LOCAL_ADDR_HIGH 5'h07
`define OFS_HOST_XFER_START_LOW 5'h08
`define OFS_HOST_XFER_START_HIGH 5'h09
`define OFS_HOST_XFER_COUNT_LOW 5'h0A
`define OFS_HOST_XFER_COUNT_HIGH 5'h0B
`define OFS_HOST_XFER_ADDR_LOW 5'h0C
`define OFS_HOST_XFER_ADDR_HIGH 5'h0D
`define OFS_ALIGN_ERROR_TALLY 5'h0E
`define OFS_CRC_ERROR_TALLY 5'h0F
`define OFS_STATION_ADDR_BASE 5'h10
`define OFS_HASH_FILTER_BASE 5'h18
`define OFS_TX_PAGE_POINTER 5'h16
`define OFS_XFER_STATUS 5'h17
`define RST_BYTE 8'h00
`define TALLY_MAX 8'hC0
`define CRC_INIT 32'hFFFFFFFF
`define CRC_POLY 32'h04C11DB7
`define DEST_BITS 6'h30
`endif
